//--- meter_self_test_defines.vh
`ifndef METER_SELF_TEST_DEFINES_VH
`define METER_SELF_TEST_DEFINES_VH
// Contract
// - the digital test loads a fixed 1888 into the result counter on every range and shows it with the range's point.
// - the digital test steps through all ranges on its own, with no operator range choice.
// - the digital test runs whatever the analog side does; only the sample interval shortens without the 4x timing.
// - internal trigger repeats the sequence endlessly; external trigger advances one step per manual press.
// - the analog test integrates the reference for 1000 counts, then discharges on it, counting until it completes.
// - the phase drive is in phase for the primary value and shifted 90 degrees for the dissipation value.
// - the analog test runs on every range in turn for the inductance, capacitance and resistance functions.
// - a pass shows a primary of 1000 plus or minus 5 counts and a dissipation of 0 to 5 counts; else a fault.
// - a null-detect stuck low on working ranges makes the primary read 1999.
// - a ranging failure with null-detect stuck at either level blanks the display.
// - a null-detect stuck high gives -000 on every function and range.
// - whenever the primary shows -000 the dissipation display is blanked.
// - the state code steps by one when the branch qualifier is high, otherwise it holds or jumps to its target.
// - the digital test result does not depend on anything at the unknown terminals.
// - an analog over-count shows 1999 on both displays and lights the out-of-range lamp.

// register byte addresses
`define ADDR_CTRL       8'h00
`define ADDR_STATUS     8'h04
`define ADDR_RESULT     8'h08
`define LOG_SEL_HI      2'h1
// field positions
`define CTRL_TRIG_EXT   0
`define STATUS_FAIL     8
`define STATUS_PASS     9
// test-select switch codes
`define MODE_NORMAL     2'h0
`define MODE_DIGITAL    2'h1
`define MODE_ANALOG     2'h2
// counts
`define DIG_FIXED_COUNT 11'h760
`define INTEG_COUNT     11'h3E8
`define OVER_COUNT      11'h7CF
`define PASS_LO         11'h3E3
`define PASS_HI         11'h3ED
`define DISS_MAX        11'h005
`define LAST_RANGE      4'h9
`define LAST_FUNC       2'h2
// point position per range, two bits per range, range 0 lowest
`define DP_TABLE        20'h06218
`define DP_DISS         2'h3
// sample pacing
`define QF_LOSS_LIMIT   8'hC8
`define FAST_DIV        8'h10
`define HOLD_TICKS      11'h0FA
`endif

//--- result_log_mem.v
`timescale 1ns/100ps
`default_nettype none
module result_log_mem (
  // clock
  input  wire        pclk,
  // write port
  input  wire        wr_en,
  input  wire [3:0]  wr_addr,
  input  wire [31:0] wr_data,
  // read port
  input  wire [3:0]  rd_addr,
  output reg  [31:0] rd_data
);
  reg [31:0] mem [0:15];

  // one write and one registered read per clock
  always @(posedge pclk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule // result_log_mem
`default_nettype wire

//--- meter_self_test_sequencer.v
`timescale 1ns/100ps
`default_nettype none
`include "meter_self_test_defines.vh"
module meter_self_test_sequencer (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // front panel and switch
  input  wire [1:0]  test_select,
  input  wire        manual_step,
  // from analog section
  input  wire        null_detect,
  input  wire        quad_freq_timing_input,
  input  wire        range_fault,
  // to analog section
  output wire        integrate_en,
  output wire        discharge_en,
  output reg         phase_90,
  output reg  [3:0]  range_code,
  output reg  [1:0]  func_code,
  // displays
  output reg  [10:0] primary_count,
  output reg  [1:0]  primary_dp,
  output reg         primary_neg,
  output reg         primary_blank,
  output reg  [10:0] diss_count,
  output reg  [1:0]  diss_dp,
  output reg         diss_blank,
  output reg         out_of_range
);
  localparam [2:0] ST_IDLE  = 3'd0;
  localparam [2:0] ST_START = 3'd1;
  localparam [2:0] ST_DLOAD = 3'd2;
  localparam [2:0] ST_INTEG = 3'd3;
  localparam [2:0] ST_DISCH = 3'd4;
  localparam [2:0] ST_PHASE = 3'd5;
  localparam [2:0] ST_SHOW  = 3'd6;
  localparam [2:0] ST_HOLD  = 3'd7;

  // point position of a range from the packed table
  function [1:0] dp_of;
    input [3:0] rng;
    reg   [19:0] sh;
    begin
      sh    = `DP_TABLE >> {rng, 1'b0};
      dp_of = sh[1:0];
    end
  endfunction

  // state step: qualifier high steps by one, low holds or jumps
  function [2:0] step_code;
    input [2:0] cur;
    input       branch_qualifier;
    input [2:0] target;
    begin
      if (branch_qualifier) begin
        step_code = cur + 3'd1;
      end else begin
        step_code = target;
      end
    end
  endfunction

  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg  [10:0] cnt_reg;
  reg  [10:0] prim_raw_reg;
  reg  [10:0] diss_raw_reg;
  reg         trig_ext_reg;
  reg         fail_reg;
  reg         pass_reg;
  reg  [1:0]  mode_reg;
  reg         step_d_reg;
  reg         qf_d_reg;
  reg  [7:0]  qf_gap_reg;
  reg         qf_absent_reg;
  reg  [7:0]  fast_div_reg;
  reg         log_wait_reg;
  reg         log_we_reg;
  reg  [3:0]  log_ptr_reg;
  wire [31:0] log_rdata;
  wire        qf_edge;
  wire        tick;
  wire        step_press;
  wire        trig;
  wire        is_log;
  wire        mapped;
  wire        setup;
  wire        access;
  wire        wr_take;
  reg         branch_qualifier;
  reg  [2:0]  target;
  reg         entry_pass;

  // analog drives follow the state code
  assign integrate_en = (state_reg == ST_INTEG);
  assign discharge_en = (state_reg == ST_DISCH);

  // pacing tick: 4x timing edges, or a faster local tick once it is lost
  assign qf_edge    = quad_freq_timing_input & ~qf_d_reg;
  assign tick       = qf_absent_reg ? (fast_div_reg == 8'h00) : qf_edge;
  assign step_press = manual_step & ~step_d_reg;
  assign trig       = trig_ext_reg ? step_press : 1'b1;

  // pacing and edge-detect registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qf_d_reg      <= 1'b0;
      step_d_reg    <= 1'b0;
      qf_gap_reg    <= 8'h00;
      qf_absent_reg <= 1'b0;
      fast_div_reg  <= 8'h00;
    end else begin
      qf_d_reg   <= quad_freq_timing_input;
      step_d_reg <= manual_step;
      if (qf_edge) begin
        qf_gap_reg    <= 8'h00;
        qf_absent_reg <= 1'b0;
      end else if (qf_gap_reg == `QF_LOSS_LIMIT) begin
        qf_absent_reg <= 1'b1; // shorter interval without the timing input
      end else begin
        qf_gap_reg <= qf_gap_reg + 8'h01;
      end
      if (fast_div_reg == `FAST_DIV) begin
        fast_div_reg <= 8'h00;
      end else begin
        fast_div_reg <= fast_div_reg + 8'h01;
      end
    end
  end

  // qualifier and branch target of each state
  always @* begin
    branch_qualifier   = 1'b0;
    target = state_reg;
    case (state_reg)
      ST_IDLE: begin
        branch_qualifier = trig & (mode_reg != `MODE_NORMAL);
      end
      ST_START: begin
        branch_qualifier   = (mode_reg == `MODE_DIGITAL);
        target = (mode_reg == `MODE_ANALOG) ? ST_INTEG : ST_IDLE;
      end
      ST_DLOAD: begin
        target = ST_SHOW; // fixed count path skips the analog states
      end
      ST_INTEG: begin
        branch_qualifier = tick & (cnt_reg == `INTEG_COUNT - 11'h001);
      end
      ST_DISCH: begin
        branch_qualifier = null_detect | (tick & (cnt_reg == `OVER_COUNT));
      end
      ST_PHASE: begin
        branch_qualifier   = phase_90;
        target = ST_INTEG;
      end
      ST_SHOW: begin
        branch_qualifier = 1'b1;
      end
      ST_HOLD: begin
        branch_qualifier   = 1'b0;
        target = (tick & (cnt_reg == `HOLD_TICKS)) ? ST_IDLE : ST_HOLD;
      end
      default: begin
        branch_qualifier   = 1'b0;
        target = ST_IDLE;
      end
    endcase
  end

  // normal mode, once the switch is sampled in the initial state, holds the state code there
  always @* begin
    if (mode_reg == `MODE_NORMAL) begin
      state_next = ST_IDLE;
    end else begin
      state_next = step_code(state_reg, branch_qualifier, target);
    end
  end

  // pass window on the finished analog readings
  always @* begin
    entry_pass = (prim_raw_reg >= `PASS_LO) && (prim_raw_reg <= `PASS_HI) &&
                 (diss_raw_reg <= `DISS_MAX);
  end

  // state code, counter and sequencing registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= ST_IDLE;
      mode_reg     <= `MODE_NORMAL;
      cnt_reg      <= 11'h000;
      prim_raw_reg <= 11'h000;
      diss_raw_reg <= 11'h000;
      phase_90     <= 1'b0;
      range_code   <= 4'h0;
      func_code    <= 2'h0;
    end else begin
      state_reg <= state_next;
      if (state_reg == ST_IDLE) begin
        mode_reg <= test_select; // switch sampled between steps
      end
      case (state_reg)
        ST_START: begin
          cnt_reg  <= 11'h000;
          phase_90 <= 1'b0; // primary in phase
        end
        ST_DLOAD: begin
          prim_raw_reg <= `DIG_FIXED_COUNT;
          diss_raw_reg <= `DIG_FIXED_COUNT;
        end
        ST_INTEG: begin
          if (branch_qualifier) begin
            cnt_reg <= 11'h000;
          end else if (tick) begin
            cnt_reg <= cnt_reg + 11'h001;
          end
        end
        ST_DISCH: begin
          if (!branch_qualifier && tick) begin
            cnt_reg <= cnt_reg + 11'h001;
          end
        end
        ST_PHASE: begin
          cnt_reg <= 11'h000;
          if (phase_90) begin
            diss_raw_reg <= cnt_reg;
          end else begin
            prim_raw_reg <= cnt_reg;
            phase_90     <= 1'b1; // dissipation pass shifted 90 degrees
          end
        end
        ST_SHOW: begin
          cnt_reg <= 11'h000;
        end
        ST_HOLD: begin
          if (tick) begin
            cnt_reg <= cnt_reg + 11'h001;
          end
          if (state_next == ST_IDLE) begin
            // self stepping of range, then function
            if (range_code == `LAST_RANGE) begin
              range_code <= 4'h0;
              func_code  <= (func_code == `LAST_FUNC) ? 2'h0 : func_code + 2'h1;
            end else begin
              range_code <= range_code + 4'h1;
            end
          end
        end
        default: begin
          cnt_reg <= cnt_reg;
        end
      endcase
    end
  end

  // display latch at the end of each measurement
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      primary_count <= 11'h000;
      primary_dp    <= 2'h0;
      primary_neg   <= 1'b0;
      primary_blank <= 1'b1;
      diss_count    <= 11'h000;
      diss_dp       <= 2'h0;
      diss_blank    <= 1'b1;
      out_of_range  <= 1'b0;
      pass_reg      <= 1'b0;
    end else if (state_reg == ST_SHOW) begin
      primary_dp    <= dp_of(range_code);
      diss_dp       <= `DP_DISS;
      primary_count <= prim_raw_reg;
      diss_count    <= diss_raw_reg;
      primary_neg   <= 1'b0;
      primary_blank <= 1'b0;
      diss_blank    <= 1'b0;
      out_of_range  <= 1'b0;
      pass_reg      <= 1'b0;
      if (mode_reg == `MODE_DIGITAL) begin
        primary_count <= `DIG_FIXED_COUNT; // terminals play no part
        diss_count    <= `DIG_FIXED_COUNT;
      end else if (range_fault) begin
        primary_blank <= 1'b1;
        diss_blank    <= 1'b1;
      end else if (prim_raw_reg == `OVER_COUNT) begin
        primary_count <= `OVER_COUNT;
        diss_count    <= `OVER_COUNT;
        out_of_range  <= 1'b1;
      end else if (prim_raw_reg == 11'h000) begin
        primary_neg <= 1'b1; // reads -000
        diss_blank  <= 1'b1;
      end else begin
        pass_reg <= entry_pass;
      end
    end
  end

  // apb decode
  assign is_log  = (paddr[7:6] == `LOG_SEL_HI);
  assign mapped  = is_log || (paddr == `ADDR_CTRL) || (paddr == `ADDR_STATUS) || (paddr == `ADDR_RESULT);
  assign setup   = psel & ~penable;
  assign access  = psel & penable;
  assign pready  = access & (~is_log | log_wait_reg);
  assign pslverr = pready & ~mapped;
  assign wr_take = pready & pwrite & mapped;

  // control, sticky fault flag and read data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_ext_reg <= 1'b0;
      fail_reg     <= 1'b0;
      log_wait_reg <= 1'b0;
      prdata       <= 32'h00000000;
    end else begin
      log_wait_reg <= access & is_log & ~log_wait_reg;
      if (wr_take && paddr == `ADDR_CTRL) begin
        trig_ext_reg <= pwdata[`CTRL_TRIG_EXT];
      end
      // a new fault wins over a write-one clear
      if (state_reg == ST_SHOW && mode_reg == `MODE_ANALOG && !entry_pass) begin
        fail_reg <= 1'b1;
      end else if (wr_take && paddr == `ADDR_STATUS && pwdata[`STATUS_FAIL]) begin
        fail_reg <= 1'b0;
      end
      if (setup) begin
        case (paddr)
          `ADDR_CTRL:   prdata <= {31'h00000000, trig_ext_reg};
          `ADDR_STATUS: prdata <= {16'h0000, range_code, func_code, pass_reg, fail_reg,
                                   mode_reg, phase_90, qf_absent_reg, 1'b0, state_reg};
          `ADDR_RESULT: prdata <= {5'h00, diss_raw_reg, 5'h00, prim_raw_reg};
          default:      prdata <= 32'h00000000;
        endcase
      end else if (access && is_log && !log_wait_reg) begin
        prdata <= log_rdata;
      end
    end
  end

  // result log write pointer, one entry per shown reading
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      log_we_reg  <= 1'b0;
      log_ptr_reg <= 4'h0;
    end else begin
      log_we_reg <= (state_reg == ST_SHOW);
      if (log_we_reg) begin
        log_ptr_reg <= log_ptr_reg + 4'h1;
      end
    end
  end

  result_log_mem u_log (
    .pclk    (pclk),
    .wr_en   (log_we_reg),
    .wr_addr (log_ptr_reg),
    .wr_data ({func_code, range_code, primary_neg, primary_blank, diss_blank, out_of_range,
               1'b0, diss_count, 1'b0, primary_count[8:0]} ),
    .rd_addr (paddr[5:2]),
    .rd_data (log_rdata)
  );
endmodule // meter_self_test_sequencer
`default_nettype wire

//--- sequencer_chk.sv
`timescale 1ns/100ps
`default_nettype none
module sequencer_chk (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // watched ports
  input wire [1:0]  test_select,
  input wire        quad_freq_timing_input,
  input wire        integrate_en,
  input wire        discharge_en,
  input wire        phase_90,
  input wire [3:0]  range_code,
  input wire [1:0]  func_code,
  input wire [10:0] primary_count,
  input wire        primary_neg,
  input wire        primary_blank,
  input wire [10:0] diss_count,
  input wire        diss_blank,
  input wire        out_of_range
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  reg        qf_q;
  reg [10:0] tick_cnt;
  // timing ticks seen while integrating
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      qf_q     <= 1'b0;
      tick_cnt <= 11'h000;
    end else begin
      qf_q <= quad_freq_timing_input;
      if (!integrate_en)
        tick_cnt <= 11'h000;
      else if (quad_freq_timing_input && !qf_q)
        tick_cnt <= tick_cnt + 11'h001;
    end
  end
  integ_len_a: assert property ($fell(integrate_en) |-> tick_cnt >= 11'h3E7 && tick_cnt <= 11'h3E9)
    else $error("integration length wrong");
  disch_after_a: assert property ($rose(discharge_en) |-> $past(integrate_en))
    else $error("discharge without integration");
  phase_turn_a: assert property ($fell(discharge_en) && !phase_90 && test_select == 2'h2 |-> ##[1:3] phase_90)
    else $error("phase drive not turned");
  phase_hold_a: assert property (integrate_en && $past(integrate_en) |-> $stable(phase_90))
    else $error("phase drive moved mid integration");
  neg_blank_a: assert property (primary_neg && !primary_blank |-> diss_blank)
    else $error("dissipation shown beside negative zero");
  over_count_a: assert property (
    !primary_blank && primary_count == 11'h7CF |-> out_of_range && diss_count == 11'h7CF)
    else $error("over count display wrong");
  dig_count_a: assert property (
    $changed(primary_count) && test_select == 2'h1 |-> primary_count == 11'h760 && diss_count == 11'h760)
    else $error("digital count wrong");
  range_step_a: assert property (
    $changed(range_code) |-> range_code == $past(range_code) + 4'h1 || range_code == 4'h0)
    else $error("range skipped");
  range_bound_a: assert property (range_code <= 4'h9 && func_code <= 2'h2)
    else $error("range or function out of bounds");
  cover property ($rose(discharge_en));
  cover property (primary_neg);
  cover property (out_of_range);
endmodule // sequencer_chk
bind meter_self_test_sequencer sequencer_chk u_chk (.pclk(pclk), .presetn(presetn), .test_select(test_select),
  .quad_freq_timing_input(quad_freq_timing_input), .integrate_en(integrate_en), .discharge_en(discharge_en),
  .phase_90(phase_90), .range_code(range_code), .func_code(func_code), .primary_count(primary_count),
  .primary_neg(primary_neg), .primary_blank(primary_blank), .diss_count(diss_count), .diss_blank(diss_blank),
  .out_of_range(out_of_range));
`default_nettype wire

//--- analog_side_model.sv
`timescale 1ns/100ps
`default_nettype none
module analog_side_model (
  // clock and reset
  input wire         pclk,
  input wire         presetn,
  // bench controls
  input wire         qf_on,
  input wire  [1:0]  null_mode,
  input wire  [10:0] target_p,
  input wire  [10:0] target_d,
  input wire         noise,
  // from the sequencer
  input wire         discharge_en,
  input wire         phase_90,
  // to the sequencer
  output logic       null_detect,
  output logic       quad_freq_timing_input
);
  logic [11:0] dis_cnt;
  // timing source stands low when absent; ticks counted during discharge
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      quad_freq_timing_input <= 1'b0;
      dis_cnt                <= 12'h000;
    end else begin
      quad_freq_timing_input <= qf_on & ~quad_freq_timing_input;
      if (!discharge_en)
        dis_cnt <= 12'h000;
      else if (qf_on && !quad_freq_timing_input)
        dis_cnt <= dis_cnt + 12'h001;
    end
  end
  // null detector: stuck low, stuck high, crossing at a target, or noise
  always @* begin
    case (null_mode)
      2'h0: null_detect = 1'b0;
      2'h1: null_detect = 1'b1;
      2'h2: null_detect = discharge_en && dis_cnt >= {1'b0, (phase_90 ? target_d : target_p)};
      default: null_detect = noise;
    endcase
  end
endmodule // analog_side_model
`default_nettype wire

//--- meter_self_test_sequencer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "meter_self_test_defines.vh"
module meter_self_test_sequencer_tb_top;
  logic        pclk, presetn, psel, penable, pwrite, manual_step, range_fault, qf_on, noise_on, err;
  logic        fault_force;
  logic [7:0]  paddr;
  logic [31:0] pwdata, seed, rd;
  logic [1:0]  test_select, null_mode;
  logic [10:0] target_p, target_d;
  wire  [31:0] prdata;
  wire         pready, pslverr, null_detect, quad_freq_timing_input, integrate_en, discharge_en, phase_90;
  wire         primary_neg, primary_blank, diss_blank, out_of_range;
  wire  [3:0]  range_code;
  wire  [1:0]  func_code, primary_dp, diss_dp;
  wire  [10:0] primary_count, diss_count;
  integer      miscompares = 0;
  integer      check_count = 0;
  integer      i;

  meter_self_test_sequencer DUT (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .test_select(test_select), .manual_step(manual_step), .null_detect(null_detect),
    .quad_freq_timing_input(quad_freq_timing_input), .range_fault(range_fault), .integrate_en(integrate_en),
    .discharge_en(discharge_en), .phase_90(phase_90), .range_code(range_code), .func_code(func_code),
    .primary_count(primary_count), .primary_dp(primary_dp), .primary_neg(primary_neg),
    .primary_blank(primary_blank), .diss_count(diss_count), .diss_dp(diss_dp), .diss_blank(diss_blank),
    .out_of_range(out_of_range));
  analog_side_model u_analog (.pclk(pclk), .presetn(presetn), .qf_on(qf_on), .null_mode(null_mode),
    .target_p(target_p), .target_d(target_d), .noise(seed[7]), .discharge_en(discharge_en),
    .phase_90(phase_90), .null_detect(null_detect), .quad_freq_timing_input(quad_freq_timing_input));

  // clock
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  function logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // point position expected per range
  function logic [1:0] dp_of(input logic [3:0] r);
    case (r)
      4'h1, 4'h4, 4'h6: dp_of = 2'h2;
      4'h2, 4'h7: dp_of = 2'h1;
      default: dp_of = 2'h0;
    endcase
  endfunction

  // random ranging and null levels while the digital test runs
  // sole driver of the seed and of the ranging fault line
  always @(posedge pclk) begin
    if (!presetn) begin
      seed        <= 32'hE70815F3;
      range_fault <= 1'b0;
    end else begin
      seed        <= noise_on ? lfsr(seed) : seed;
      range_fault <= noise_on ? seed[3] : fault_force;
    end
  end

  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count = check_count + 1;
    if (got !== exp) begin
      $display("unexpected %s expected %0h seen %0h", what, exp, got);
      miscompares = miscompares + 1;
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1); // only the watchdog ends a hung wait
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // waits for range or function to move on
  task wait_step(input integer lim);
    logic [3:0] r;
    logic [1:0] f;
    integer     n;
    r = range_code;
    f = func_code;
    n = 0;
    while (range_code === r && func_code === f && n < lim) begin
      @(posedge pclk);
      n = n + 1;
    end
    chk("step wait", 32'h1, n < lim);
  endtask

  task dig_chk(input logic [3:0] r);
    chk("digital display", {4'h0, `DIG_FIXED_COUNT, `DIG_FIXED_COUNT, dp_of(r), 2'h3, 2'h0},
      {4'h0, primary_count, diss_count, primary_dp, diss_dp, primary_blank, diss_blank});
  endtask

  task test_done;
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // watchdog
  initial begin
    repeat (80000) @(posedge pclk);
    miscompares = miscompares + 1;
    test_done;
  end

  // main sequence
  initial begin
    {presetn, psel, penable, pwrite, manual_step, fault_force, noise_on} = 7'h00;
    {paddr, pwdata, test_select} = 42'h0;
    {qf_on, null_mode, target_p, target_d} = {1'b1, 2'h3, 11'h3E8, 11'h002};
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk("reset blanks", 32'h3, {primary_blank, diss_blank});
    apb(1'b1, `ADDR_CTRL, 32'h1);
    apb(1'b0, `ADDR_CTRL, 32'h0);
    chk("trigger readback", 32'h1, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, err);
    test_select <= `MODE_DIGITAL;
    noise_on <= 1'b1;
    repeat (300) @(posedge pclk);
    chk("range before press", 32'h0, range_code);
    manual_step <= 1'b1;
    repeat (4) @(posedge pclk);
    manual_step <= 1'b0;
    wait_step(5000);
    dig_chk(4'h0);
    repeat (800) @(posedge pclk);
    chk("range after one press", 32'h1, range_code);
    apb(1'b1, `ADDR_CTRL, 32'h0);
    for (i = 1; i < 4; i = i + 1) begin
      wait_step(5000);
      dig_chk(i[3:0]);
    end
    qf_on <= 1'b0;
    wait_step(10000);
    dig_chk(4'h4);
    {qf_on, noise_on, fault_force, null_mode, test_select} <= {3'h4, 2'h2, `MODE_NORMAL};
    wait_step(2000); // the digital run already under way finishes first
    repeat (600) @(posedge pclk);
    chk("normal stays idle", 32'h6, range_code);
    test_select <= `MODE_ANALOG;
    wait_step(20000);
    chk("primary window", 32'h1, primary_count >= 11'h3E3 && primary_count <= 11'h3ED);
    chk("dissipation small", 32'h1, diss_count <= 11'h005);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk("pass flag", 32'h200, rd & 32'h300);
    target_p <= 11'h3FC;
    wait_step(20000);
    apb(1'b0, `ADDR_STATUS, 32'h0);
    chk("fail flag", 32'h100, rd & 32'h300);
    null_mode <= 2'h0;
    wait_step(30000);
    chk("stuck low flags", 32'h8, {out_of_range, primary_neg, primary_blank, diss_blank});
    chk("stuck low counts", {10'h0, `OVER_COUNT, `OVER_COUNT}, {10'h0, primary_count, diss_count});
    null_mode <= 2'h1;
    wait_step(20000);
    chk("stuck high", 32'h5, {primary_neg, primary_blank, diss_blank});
    chk("stuck high count", 32'h0, primary_count);
    fault_force <= 1'b1;
    wait_step(20000);
    chk("fault blanks", 32'h3, {primary_blank, diss_blank});
    test_done;
  end
endmodule // meter_self_test_sequencer_tb_top
`default_nettype wire
